// file: design/evu_arbiter.sv
// picks the source of the next entry at an instruction boundary
`timescale 1ns/1ps
module evu_arbiter (
    // event sources
    input wire evu_pkg::evu_exc_t exc,
    input wire logic nmi_pend,
    input wire logic nmi_block,
    input wire logic maskable_request_input_level,
    input wire logic if_flag,
    // decision
    output logic take_exc,
    output logic take_nmi,
    output logic take_maskable_request_input
);
    // exceptions of the current instruction come before async requests
    assign take_exc = exc.valid;
    // nmi wins over a maskable request at the same boundary
    assign take_nmi = !exc.valid && nmi_pend && !nmi_block;
    // nmi handler also holds off maskable requests
    assign take_maskable_request_input = !exc.valid && !take_nmi && maskable_request_input_level && if_flag
        && !nmi_block;
endmodule

// file: design/evu_sync.sv
// two-stage synchroniser for the asynchronous request pins
`timescale 1ns/1ps
module evu_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pin and synchronised level
    input wire logic pin,
    output logic level
);
    logic meta_q;
    logic level_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            meta_q <= pin;
            level_q <= meta_q;
        end
    end

    assign level = level_q;
endmodule

// file: design/evu_top.sv
// exception vectoring unit: entry, vector selection and handler return
`timescale 1ns/1ps
module evu_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // request pins
    input wire logic maskable_request_input,
    input wire logic nmi_request_input,
    // core sequencing
    input wire logic insn_boundary,
    input wire logic [31:0] cur_insn_addr,
    input wire logic [31:0] next_insn_addr,
    input wire logic [31:0] cur_flags,
    input wire evu_pkg::evu_exc_t exc_in,
    input wire logic handler_return_opcode,
    input wire logic [31:0] table_base,
    // interrupt acknowledge bus
    output logic ack_req,
    input wire logic ack_done,
    input wire logic [7:0] ack_vector,
    // stack push and pop
    output logic push_req,
    output evu_pkg::evu_frame_t push_frame,
    input wire logic push_done,
    output logic pop_req,
    input wire logic pop_done,
    input wire evu_pkg::evu_frame_t pop_frame,
    // descriptor fetch
    output logic desc_req,
    output logic [31:0] desc_addr,
    input wire logic desc_done,
    input wire evu_pkg::evu_desc_t desc_in,
    // results to the core
    output logic enter_valid,
    output logic [31:0] enter_target,
    output evu_pkg::evu_gate_t enter_gate,
    output logic [7:0] enter_vector,
    output logic enter_reserved,
    output logic enter_restartable,
    output logic resume_valid,
    output logic [31:0] resume_addr,
    output logic [31:0] resume_flags,
    output logic busy,
    output logic if_flag
);
    evu_pkg::evu_state_t state_q, state_d;
    logic maskable_request_input_s, nmi_s;
    logic nmi_s_q;
    logic nmi_pend_q, nmi_block_q;
    logic [7:0] vec_q;
    evu_pkg::evu_class_t cls_q;
    logic [31:0] ret_q, flags_q;
    logic if_q;
    logic ack_req_q, push_req_q, pop_req_q, desc_req_q;
    evu_pkg::evu_frame_t push_frame_q;
    logic [31:0] desc_addr_q;
    logic enter_valid_q, resume_valid_q;
    logic [31:0] enter_target_q, resume_addr_q, resume_flags_q;
    evu_pkg::evu_gate_t enter_gate_q;
    logic [7:0] enter_vector_q;
    logic enter_reserved_q, enter_restart_q;
    logic take_exc, take_nmi, take_maskable_request_input;

    // separate pins, each synchronised
    evu_sync u_sync_maskable_request_input (
        .clk(clk),
        .rst_b(rst_b),
        .pin(maskable_request_input),
        .level(maskable_request_input_s)
    );
    evu_sync u_sync_nmi (
        .clk(clk),
        .rst_b(rst_b),
        .pin(nmi_request_input),
        .level(nmi_s)
    );

    evu_arbiter u_arb (
        .exc(exc_in),
        .nmi_pend(nmi_pend_q),
        .nmi_block(nmi_block_q),
        .maskable_request_input_level(maskable_request_input_s),
        .if_flag(if_q),
        .take_exc(take_exc),
        .take_nmi(take_nmi),
        .take_maskable_request_input(take_maskable_request_input)
    );

    wire idle = state_q == evu_pkg::EVU_IDLE;
    // decisions only at a boundary, one sample each
    wire at_bnd = idle && insn_boundary;
    wire go_exc = at_bnd && take_exc;
    wire go_nmi = at_bnd && take_nmi;
    wire go_maskable_request_input = at_bnd && take_maskable_request_input;
    wire go_ret = at_bnd && !take_exc && !take_nmi && !take_maskable_request_input
        && handler_return_opcode;
    wire nmi_rise = nmi_s && !nmi_s_q;
    wire ret_end = state_q == evu_pkg::EVU_RET && pop_done;

    // exception return point by class
    wire exc_is_fault = exc_in.cls == evu_pkg::EVU_FAULT;
    wire exc_is_abort = exc_in.cls == evu_pkg::EVU_ABORT;
    // fault: start of insn incl. prefixes; abort: best effort, not exact
    wire [31:0] exc_ret = exc_is_fault ? exc_in.addr
        : exc_is_abort ? cur_insn_addr
        : next_insn_addr;
    // async requests resume after the finished instruction
    wire [31:0] async_ret = next_insn_addr;

    // table index: base + vector * 8
    wire [31:0] vec_off = {21'h0, vec_q, 3'h0};
    wire [31:0] entry_addr = table_base + vec_off;
    wire vec_reserved = vec_q <= evu_pkg::VEC_RESERVED_TOP;

    wire gate_int = desc_in.gate == evu_pkg::EVU_GATE_INT;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            evu_pkg::EVU_IDLE: begin
                if (go_maskable_request_input) begin
                    state_d = evu_pkg::EVU_ACK;
                end else if (go_exc || go_nmi) begin
                    state_d = evu_pkg::EVU_PUSH;
                end else if (go_ret) begin
                    state_d = evu_pkg::EVU_RET;
                end
            end
            evu_pkg::EVU_ACK: begin
                if (ack_done) begin
                    state_d = evu_pkg::EVU_PUSH;
                end
            end
            evu_pkg::EVU_PUSH: begin
                // frame on the stack before the vector is used
                if (push_done) begin
                    state_d = evu_pkg::EVU_FETCH;
                end
            end
            evu_pkg::EVU_FETCH: begin
                if (desc_done) begin
                    state_d = evu_pkg::EVU_ENTER;
                end
            end
            evu_pkg::EVU_ENTER: begin
                state_d = evu_pkg::EVU_IDLE;
            end
            evu_pkg::EVU_RET: begin
                if (pop_done) begin
                    state_d = evu_pkg::EVU_IDLE;
                end
            end
            default: begin
                state_d = evu_pkg::EVU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= evu_pkg::EVU_IDLE;
            nmi_s_q <= 1'b0;
        end else begin
            state_q <= state_d;
            nmi_s_q <= nmi_s;
        end
    end

    // nmi latch and hold-off; a new edge wins over the take
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            nmi_pend_q <= 1'b0;
            nmi_block_q <= 1'b0;
        end else begin
            if (nmi_rise) begin
                nmi_pend_q <= 1'b1;
            end else if (go_nmi) begin
                nmi_pend_q <= 1'b0;
            end
            if (go_nmi) begin
                nmi_block_q <= 1'b1;
            end else if (ret_end) begin
                nmi_block_q <= 1'b0;
            end
        end
    end

    // vector source and return frame capture
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vec_q <= 8'h00;
            cls_q <= evu_pkg::EVU_FAULT;
            ret_q <= evu_pkg::PC_RESET;
            flags_q <= evu_pkg::FLAGS_RESET;
        end else if (go_exc) begin
            // vector from the core or the trap opcode
            vec_q <= exc_in.vector;
            cls_q <= exc_in.cls;
            ret_q <= exc_ret;
            flags_q <= cur_flags;
        end else if (go_nmi) begin
            vec_q <= evu_pkg::VEC_NMI;
            cls_q <= evu_pkg::EVU_TRAP;
            ret_q <= async_ret;
            flags_q <= cur_flags;
        end else if (go_maskable_request_input) begin
            cls_q <= evu_pkg::EVU_TRAP;
            ret_q <= async_ret;
            flags_q <= cur_flags;
        end else if (state_q == evu_pkg::EVU_ACK && ack_done) begin
            vec_q <= ack_vector;
        end
    end

    // maskable enable flag
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            if_q <= evu_pkg::FLAGS_RESET[evu_pkg::IF_BIT];
        end else if (state_q == evu_pkg::EVU_FETCH && desc_done) begin
            if (gate_int) begin
                if_q <= 1'b0;
            end
        end else if (ret_end) begin
            if_q <= pop_frame.flags[evu_pkg::IF_BIT];
        end else if (idle) begin
            if_q <= cur_flags[evu_pkg::IF_BIT];
        end
    end

    // bus requests held until the matching done
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_req_q <= 1'b0;
            push_req_q <= 1'b0;
            pop_req_q <= 1'b0;
            desc_req_q <= 1'b0;
            push_frame_q <= '0;
            desc_addr_q <= 32'h0000_0000;
        end else begin
            ack_req_q <= state_d == evu_pkg::EVU_ACK;
            push_req_q <= state_d == evu_pkg::EVU_PUSH;
            pop_req_q <= state_d == evu_pkg::EVU_RET;
            desc_req_q <= state_d == evu_pkg::EVU_FETCH;
            if (state_q != evu_pkg::EVU_PUSH) begin
                push_frame_q <= '{ret_addr: go_exc || go_nmi ?
                    (go_exc ? exc_ret : async_ret) : ret_q,
                    flags: go_exc || go_nmi ? cur_flags : flags_q};
            end
            if (state_q == evu_pkg::EVU_PUSH) begin
                desc_addr_q <= entry_addr;
            end
        end
    end

    // entry and resume results
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enter_valid_q <= 1'b0;
            enter_target_q <= 32'h0000_0000;
            enter_gate_q <= evu_pkg::EVU_GATE_INT;
            enter_vector_q <= 8'h00;
            enter_reserved_q <= 1'b0;
            enter_restart_q <= 1'b0;
            resume_valid_q <= 1'b0;
            resume_addr_q <= evu_pkg::PC_RESET;
            resume_flags_q <= evu_pkg::FLAGS_RESET;
        end else begin
            enter_valid_q <= state_q == evu_pkg::EVU_FETCH && desc_done;
            resume_valid_q <= ret_end;
            if (state_q == evu_pkg::EVU_FETCH && desc_done) begin
                enter_target_q <= desc_in.target;
                enter_gate_q <= desc_in.gate;
                enter_vector_q <= vec_q;
                enter_reserved_q <= vec_reserved;
                // only faults may be restarted
                enter_restart_q <= cls_q == evu_pkg::EVU_FAULT;
            end
            if (ret_end) begin
                resume_addr_q <= pop_frame.ret_addr;
                resume_flags_q <= pop_frame.flags;
            end
        end
    end

    assign ack_req = ack_req_q;
    assign push_req = push_req_q;
    assign push_frame = push_frame_q;
    assign pop_req = pop_req_q;
    assign desc_req = desc_req_q;
    assign desc_addr = desc_addr_q;
    assign enter_valid = enter_valid_q;
    assign enter_target = enter_target_q;
    assign enter_gate = enter_gate_q;
    assign enter_vector = enter_vector_q;
    assign enter_reserved = enter_reserved_q;
    assign enter_restartable = enter_restart_q;
    assign resume_valid = resume_valid_q;
    assign resume_addr = resume_addr_q;
    assign resume_flags = resume_flags_q;
    assign busy = !idle;
    assign if_flag = if_q;
endmodule

// file: include/evu_pkg.sv
// shared types and constants for the exception vectoring unit
package evu_pkg;
    localparam int VEC_W = 8;
    localparam int ADDR_W = 32;
    localparam int NUM_VECTORS = 256;
    localparam int RESERVED_VECTORS = 32;
    localparam int SYSTEM_VECTORS = 224;
    localparam int DESC_BYTES = 8;
    localparam int DESC_SHIFT = 3;
    localparam logic [7:0] VEC_NMI = 8'h02;
    localparam logic [7:0] VEC_RESERVED_TOP = 8'h1F;
    localparam int IF_BIT = 9;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
    localparam logic [31:0] TABLE_BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        EVU_FAULT = 2'h0,
        EVU_TRAP = 2'h1,
        EVU_ABORT = 2'h2,
        EVU_SWINT = 2'h3
    } evu_class_t;

    typedef enum logic [1:0] {
        EVU_GATE_INT = 2'h0,
        EVU_GATE_TRAP = 2'h1,
        EVU_GATE_TASK = 2'h2,
        EVU_GATE_BAD = 2'h3
    } evu_gate_t;

    typedef enum logic [2:0] {
        EVU_IDLE = 3'h0,
        EVU_ACK = 3'h1,
        EVU_PUSH = 3'h3,
        EVU_FETCH = 3'h2,
        EVU_ENTER = 3'h6,
        EVU_RET = 3'h7
    } evu_state_t;

    typedef struct packed {
        logic valid;
        evu_class_t cls;
        logic [7:0] vector;
        logic [31:0] addr;
    } evu_exc_t;

    typedef struct packed {
        logic [31:0] ret_addr;
        logic [31:0] flags;
    } evu_frame_t;

    typedef struct packed {
        logic valid;
        evu_gate_t gate;
        logic [31:0] target;
    } evu_desc_t;
endpackage

// file: sim/evu_ack_model.sv
// interrupt controller model answering the acknowledge cycle
`timescale 1ns/1ps
module evu_ack_model (
    // clock
    input wire logic clk,
    // acknowledge bus
    input wire logic ack_req,
    output logic ack_done,
    output logic [7:0] ack_vector,
    // vector to return and answer delay in cycles
    input wire logic [7:0] vec,
    input wire logic [1:0] lat
);
    int cnt = 0;
    initial ack_done = 1'b0;
    always @(posedge clk) begin
        #1;
        if (ack_req && !ack_done && cnt >= lat) begin
            ack_done = 1'b1;
            cnt = 0;
        end else begin
            ack_done = 1'b0;
            cnt = ack_req ? cnt + 1 : 0;
        end
    end
    // released bus shows the inverse so a stale vector never matches
    assign ack_vector = ack_done ? vec : ~vec;
endmodule

// file: sim/evu_top_props.sv
// concurrent checks on the exception vectoring unit ports
`timescale 1ns/1ps
module evu_top_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // handshakes
    input wire logic ack_req,
    input wire logic ack_done,
    input wire logic push_req,
    input wire evu_pkg::evu_frame_t push_frame,
    input wire logic push_done,
    input wire logic pop_done,
    input wire evu_pkg::evu_frame_t pop_frame,
    input wire logic desc_req,
    input wire logic [31:0] desc_addr,
    input wire logic desc_done,
    // results
    input wire logic enter_valid,
    input wire evu_pkg::evu_gate_t enter_gate,
    input wire logic [7:0] enter_vector,
    input wire logic enter_reserved,
    input wire logic resume_valid,
    input wire logic [31:0] resume_addr,
    input wire logic [31:0] resume_flags,
    input wire logic if_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_desc_end;
        desc_done ##1 enter_valid;
    endsequence
    sequence s_pop_end;
        pop_done ##1 resume_valid;
    endsequence
    a_enter_after_desc: assert property (desc_done |-> s_desc_end)
        else $error("entry did not follow descriptor");
    a_resume_after_pop: assert property (pop_done |-> s_pop_end)
        else $error("resume did not follow pop");
    a_resume_frame: assert property (resume_valid |->
        resume_addr == $past(pop_frame.ret_addr)
        && resume_flags == $past(pop_frame.flags))
        else $error("resume state differs from popped frame");
    a_push_first: assert property ($rose(desc_req) |-> $past(push_done))
        else $error("descriptor fetch before stack push");
    a_reserved_range: assert property (enter_valid |->
        enter_reserved == (enter_vector <= 8'h1F))
        else $error("reserved marking wrong");
    a_int_gate_if: assert property (enter_valid
        && enter_gate == evu_pkg::EVU_GATE_INT |-> !if_flag)
        else $error("interrupt gate left enable set");
    a_desc_hold: assert property (desc_req && !desc_done |=>
        desc_req && $stable(desc_addr))
        else $error("descriptor request dropped or moved");
    a_push_hold: assert property (push_req && !push_done |=>
        push_req && $stable(push_frame))
        else $error("push request dropped or moved");
    a_ack_hold: assert property (ack_req && !ack_done |=> ack_req)
        else $error("acknowledge dropped early");
    a_ack_then_push: assert property (ack_done |=> push_req && !ack_req)
        else $error("push did not follow acknowledge");
    c_nmi_entry: cover property (enter_valid && enter_vector == 8'h02);
endmodule
bind evu_top evu_top_props u_props (.clk(clk), .rst_b(rst_b),
    .ack_req(ack_req), .ack_done(ack_done), .push_req(push_req),
    .push_frame(push_frame), .push_done(push_done), .pop_done(pop_done),
    .pop_frame(pop_frame), .desc_req(desc_req), .desc_addr(desc_addr),
    .desc_done(desc_done), .enter_valid(enter_valid),
    .enter_gate(enter_gate), .enter_vector(enter_vector),
    .enter_reserved(enter_reserved), .resume_valid(resume_valid),
    .resume_addr(resume_addr), .resume_flags(resume_flags),
    .if_flag(if_flag));

// file: sim/tb_top.sv
// self-checking bench for the exception vectoring unit
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic mri = 1'b0, nri = 1'b0, ib = 1'b0, hro = 1'b0;
    logic [31:0] cia = 32'h0, nia = 32'h0, cf = 32'h202, base = 32'h0;
    evu_pkg::evu_exc_t exc = '0;
    logic ack_req, ack_done, push_req, pop_req, desc_req;
    logic push_done = 1'b0, pop_done = 1'b0, desc_done = 1'b0;
    logic [7:0] ack_vec = 8'h0, ack_vector, enter_vector;
    logic [1:0] lat = 2'h0;
    logic [31:0] daddr, er, desc_addr, enter_target, resume_addr, resume_flags;
    evu_pkg::evu_frame_t push_frame, pop_frame, frame, pop_good = '0;
    evu_pkg::evu_desc_t desc_in, desc_good;
    evu_pkg::evu_gate_t gsel = evu_pkg::EVU_GATE_INT, enter_gate;
    logic enter_valid, resume_valid, busy, if_flag;
    logic enter_reserved, enter_restartable;
    int bad_count = 0, checks = 0, cyc = 0, seed = 32'he14f, i;

    always #20 clk = ~clk;
    evu_top DUT (.clk(clk), .rst_b(rst_b), .maskable_request_input(mri),
        .nmi_request_input(nri), .insn_boundary(ib), .cur_insn_addr(cia),
        .next_insn_addr(nia), .cur_flags(cf), .exc_in(exc),
        .handler_return_opcode(hro), .table_base(base),
        .ack_req(ack_req), .ack_done(ack_done), .ack_vector(ack_vector),
        .push_req(push_req), .push_frame(push_frame), .push_done(push_done),
        .pop_req(pop_req), .pop_done(pop_done), .pop_frame(pop_frame),
        .desc_req(desc_req), .desc_addr(desc_addr), .desc_done(desc_done),
        .desc_in(desc_in), .enter_valid(enter_valid),
        .enter_target(enter_target), .enter_gate(enter_gate),
        .enter_vector(enter_vector), .enter_reserved(enter_reserved),
        .enter_restartable(enter_restartable), .resume_valid(resume_valid),
        .resume_addr(resume_addr), .resume_flags(resume_flags),
        .busy(busy), .if_flag(if_flag));
    evu_ack_model u_ctrl (.clk(clk), .ack_req(ack_req), .ack_done(ack_done),
        .ack_vector(ack_vector), .vec(ack_vec), .lat(lat));

    // target is a mangling of the entry address so a wrong fetch shows
    function automatic logic [31:0] tgt(input logic [31:0] a);
        return a ^ 32'h5A5A_0000;
    endfunction
    // idle answer lines carry the inverse, never the last good value
    assign desc_good = {1'b1, gsel, tgt(desc_addr)};
    assign desc_in = desc_done ? desc_good : ~desc_good;
    assign pop_frame = pop_done ? pop_good : ~pop_good;
    always @(posedge clk) begin
        #1;
        push_done = push_req && !push_done;
        pop_done = pop_req && !pop_done;
        desc_done = desc_req && !desc_done;
        if (push_done) frame = push_frame;
        if (desc_done) daddr = desc_addr;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one boundary, then wait bounded for entry or resume
    task automatic take(output int n, output logic a);
        n = 0;
        a = 1'b0;
        ib = 1'b1;
        step(1);
        ib = 1'b0;
        exc.valid = 1'b0;
        hro = 1'b0;
        while (enter_valid !== 1'b1 && resume_valid !== 1'b1 && n < 40) begin
            if (ack_req === 1'b1) a = 1'b1;
            step(1);
            n++;
        end
    endtask
    task automatic go(input logic [7:0] v, input logic [31:0] r,
        input logic ak, input logic rs);
        int n;
        logic a;
        take(n, a);
        chk(n < 40, 1'b1);
        chk(enter_vector, v);
        chk(frame.ret_addr, r);
        chk(frame.flags, cf);
        chk(daddr, base + {v, 3'h0});
        chk(enter_target, tgt(daddr));
        chk(enter_gate, gsel);
        chk(enter_reserved, v <= 8'h1F);
        chk(enter_restartable, rs);
        chk(a, ak);
        chk(if_flag, gsel == evu_pkg::EVU_GATE_INT ? 1'b0 : cf[9]);
        step(1);
        chk(busy, 1'b0);
    endtask
    task automatic none();
        int n;
        logic a;
        take(n, a);
        chk(n, 40);
    endtask
    task automatic ret(input logic [31:0] ra);
        int n;
        logic a;
        pop_good = {ra, 32'($random(seed))};
        hro = 1'b1;
        take(n, a);
        chk(resume_valid, 1'b1);
        chk(resume_addr, ra);
        chk(resume_flags, pop_good.flags);
        step(1);
    endtask
    task automatic nmi();
        nri = 1'b1;
        step(3);
        nri = 1'b0;
        step(3);
    endtask

    initial begin
        step(12);
        rst_b = 1'b1;
        step(3);
        base = $random(seed);
        for (i = 0; i < 12; i++) begin
            cia = $random(seed);
            nia = cia + 32'h4;
            lat = 2'($random(seed));
            exc.valid = 1'b1;
            exc.cls = evu_pkg::evu_class_t'(i % 4);
            exc.vector = 8'($random(seed));
            if (i == 0) exc.vector = evu_pkg::VEC_RESERVED_TOP;
            if (i == 1) exc.vector = 8'hFF;
            if (i == 2) exc.vector = 8'h20;
            // fault address sits at or below cia as if prefixes led it
            exc.addr = cia - (i % 3);
            gsel = evu_pkg::evu_gate_t'(i % 3);
            er = (i % 4 == 0) ? exc.addr : (i % 4 == 2) ? cia : nia;
            go(exc.vector, er, 1'b0, i % 4 == 0);
        end
        $display("test exceptions done");
        mri = 1'b1;
        ack_vec = 8'h20 | 8'($random(seed));
        gsel = evu_pkg::EVU_GATE_INT;
        step(3);
        go(ack_vec, nia, 1'b1, 1'b0);
        cf[9] = 1'b0;
        step(2);
        none();
        cf[9] = 1'b1;
        $display("test maskable done");
        nmi();
        go(evu_pkg::VEC_NMI, nia, 1'b0, 1'b0);
        nmi();
        none();
        ret(nia);
        go(evu_pkg::VEC_NMI, nia, 1'b0, 1'b0);
        ret(nia);
        go(ack_vec, nia, 1'b1, 1'b0);
        mri = 1'b0;
        $display("test nmi done");
        nmi();
        exc.valid = 1'b1;
        exc.cls = evu_pkg::EVU_FAULT;
        exc.vector = 8'h0D;
        exc.addr = cia;
        go(8'h0D, cia, 1'b0, 1'b1);
        go(evu_pkg::VEC_NMI, nia, 1'b0, 1'b0);
        ret(nia);
        $display("test priority done");
        final_report();
    end
endmodule
